// File: vioc_pkg.sv
package vioc_pkg;
    // Register map
    localparam logic [11:0] VIOC_CTRL_ADDR    = 12'h000;
    localparam logic [15:0] VIOC_CTRL_RESET   = 16'h0000;
    localparam logic [15:0] VIOC_CTRL_WMASK   = 16'h7FFF;
    localparam logic [15:0] VIOC_READ_ZERO    = 16'h0000;
    // Control field positions
    localparam int VIOC_SYNC_REMAP_BIT        = 14;
    localparam int VIOC_FLAG_REFRESH_BIT      = 12;
    localparam int VIOC_CHECK_INSERT_BIT      = 11;
    localparam int VIOC_H_SELECT_BIT          = 10;
    localparam int VIOC_ANC_FIFO_BIT          = 9;
    localparam int VIOC_PIN_OVERRIDE_BIT      = 7;
    localparam int VIOC_FORMAT_SEL_BIT        = 6;
    localparam int VIOC_BAD_WORD_BIT          = 4;
    localparam int VIOC_ANC_CHECKSUM_BIT      = 3;
    localparam int VIOC_LINE_CRC_BIT          = 2;
    localparam int VIOC_LINE_NUMBER_BIT       = 1;
    localparam int VIOC_SYNC_INSERT_BIT       = 0;
    // Command word layout
    localparam int VIOC_CMD_READ_BIT          = 15;
    localparam int VIOC_CMD_AINC_BIT          = 12;
    localparam logic [3:0]  VIOC_WORD_LAST    = 4'hF;
    localparam logic [3:0]  VIOC_CNT_ZERO     = 4'h0;
    localparam logic [3:0]  VIOC_CNT_ONE      = 4'h1;
    localparam logic [11:0] VIOC_ADDR_ONE     = 12'h001;
    localparam logic [11:0] VIOC_ADDR_ZERO    = 12'h000;
    localparam logic [15:0] VIOC_WORD_ZERO    = 16'h0000;
    // Serial link phase
    typedef enum logic [1:0] {
        VIOC_IDLE  = 2'b00,
        VIOC_CMD   = 2'b01,
        VIOC_WRITE = 2'b10,
        VIOC_READ  = 2'b11
    } vioc_phase_t;
endpackage

// File: vioc_serial.sv
`timescale 1ns/10ps
`default_nettype none
module vioc_serial (
    input  wire logic                   sys_clk,      // System clock
    input  wire logic                   reset,        // Async reset, high
    input  wire logic                   host_sclk,    // Host burst clock
    input  wire logic                   host_sdin,    // Host serial data in
    input  wire logic                   host_cs_n,    // Host select, low
    input  wire logic [15:0]            rd_data,      // Read word at addr
    output logic                        host_sdout,   // Serial data out
    output logic [11:0]                 addr,         // Current address
    output logic                        wr_stb,       // Write pulse
    output logic [15:0]                 wr_data       // Write word
);
    import vioc_pkg::*;

    vioc_phase_t phase_reg, phase_next;
    logic        sclk_reg;
    logic [3:0]  cnt_reg;
    logic [15:0] shin_reg;
    logic [15:0] shout_reg;
    logic        ainc_reg;
    logic        load_reg;
    logic [11:0] addr_reg;
    logic        sdout_reg;
    logic        wr_reg;
    logic [15:0] wdat_reg;

    // Edge and word decode
    wire         rise      = host_sclk & ~sclk_reg & ~host_cs_n;
    wire         fall      = ~host_sclk & sclk_reg & ~host_cs_n;
    wire [15:0]  word      = {shin_reg[14:0], host_sdin};
    wire         word_done = rise & (cnt_reg == VIOC_WORD_LAST);
    wire         cmd_done  = word_done & (phase_reg == VIOC_CMD);
    wire         data_done = word_done & (phase_reg != VIOC_CMD);
    wire         addr_step = ainc_reg & ((data_done & (phase_reg == VIOC_READ)) | wr_reg); // Write steps after strobe

    // Phase sequencing
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            VIOC_IDLE:  phase_next = host_cs_n ? VIOC_IDLE : VIOC_CMD;
            VIOC_CMD:   if (cmd_done) begin
                            phase_next = word[VIOC_CMD_READ_BIT] ? VIOC_READ : VIOC_WRITE;
                        end
            VIOC_WRITE: phase_next = VIOC_WRITE;
            VIOC_READ:  phase_next = VIOC_READ;
            default:    phase_next = VIOC_IDLE;
        endcase
        if (host_cs_n) begin
            phase_next = VIOC_IDLE;
        end
    end

    // Shift and count
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            phase_reg <= VIOC_IDLE;
            sclk_reg  <= 1'b0;
            cnt_reg   <= VIOC_CNT_ZERO;
            shin_reg  <= VIOC_WORD_ZERO;
            ainc_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            sclk_reg  <= host_sclk;
            cnt_reg   <= host_cs_n ? VIOC_CNT_ZERO : (rise ? cnt_reg + VIOC_CNT_ONE : cnt_reg);
            shin_reg  <= rise ? word : shin_reg;
            ainc_reg  <= cmd_done ? word[VIOC_CMD_AINC_BIT] : ainc_reg;
        end
    end

    // Address, write strobe and read loading
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            addr_reg <= VIOC_ADDR_ZERO;
            wr_reg   <= 1'b0;
            wdat_reg <= VIOC_WORD_ZERO;
            load_reg <= 1'b0;
        end else begin
            addr_reg <= cmd_done ? word[11:0] : (addr_step ? addr_reg + VIOC_ADDR_ONE : addr_reg);
            wr_reg   <= data_done & (phase_reg == VIOC_WRITE);
            wdat_reg <= data_done ? word : wdat_reg;
            load_reg <= (cmd_done & word[VIOC_CMD_READ_BIT]) | (data_done & (phase_reg == VIOC_READ));
        end
    end

    // Read data out on falling edges, loop-through otherwise
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            shout_reg <= VIOC_WORD_ZERO;
            sdout_reg <= 1'b0;
        end else begin
            if (load_reg) begin
                shout_reg <= rd_data;
            end else if (fall & (phase_reg == VIOC_READ)) begin
                shout_reg <= {shout_reg[14:0], 1'b0};
            end
            sdout_reg <= (phase_reg == VIOC_READ) ? (fall ? shout_reg[15] : sdout_reg) : host_sdin;
        end
    end

    assign host_sdout = sdout_reg;
    assign addr       = addr_reg;
    assign wr_stb     = wr_reg;
    assign wr_data    = wdat_reg;
endmodule // vioc_serial
`default_nettype wire

// File: vioc_top.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1: bit 14 set stops sync word remapping on stream one, level A, HD, SD.
// R2: bit 12 set stops updating of error detection flags.
// R3: bit 11 set stops error check word correction and insertion.
// R4: select bit 10 low: H high over whole line blanking incl. sync words.
// R5: select bit 10 high: H follows the H bit of received sync words.
// R6: H selection only acts while the F V H timing format is chosen.
// R7: bit 9 set disables the ancillary capture FIFO.
// R8: bit 7 set ignores the format pin and uses the register format bit.
// R9: format bit 0 gives F V H timing, 1 gives CEA-861 timing.
// R10: bit 4 set stops illegal word remapping.
// R11: bit 3 set stops ancillary checksum insertion.
// R12: bit 2 set stops line CRC word insertion.
// R13: bit 1 set stops line number insertion.
// R14: bit 0 set stops sync word insertion.
// R15: reserved bits do nothing; top bit reads zero, others keep writes.
module vioc_top (
    input  wire logic                   sys_clk,                        // System clock
    input  wire logic                   reset,                          // Async reset, high
    input  wire logic                   host_sclk,                      // Host burst clock
    input  wire logic                   host_sdin,                      // Host serial data in
    input  wire logic                   host_cs_n,                      // Host select, low
    output logic                        host_sdout,                     // Host serial data out
    input  wire logic                   timing_format_pin,              // Format select pin
    input  wire logic                   line_blank,                     // Line blanking incl. sync words
    input  wire logic                   trs_h_bit,                      // H bit of received sync words
    output logic                        sync_word_remap_off,            // Stop sync word remap
    output logic                        error_flag_refresh_off,         // Stop flag update
    output logic                        error_check_insert_off,         // Stop check word insert
    output logic                        ancillary_capture_fifo_off,     // Disable capture FIFO
    output logic                        bad_word_remap_off,             // Stop illegal word remap
    output logic                        ancillary_checksum_insert_off,  // Stop checksum insert
    output logic                        line_crc_insert_off,            // Stop line CRC insert
    output logic                        line_number_insert_off,         // Stop line number insert
    output logic                        sync_word_insert_off,           // Stop sync word insert
    output logic                        cea_timing_sel,                 // Effective CEA-861 format
    output logic                        h_indication                    // Horizontal blanking out
);
    import vioc_pkg::*;

    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [10:0] outs_reg;
    logic [10:0] outs_next;
    logic [11:0] addr;
    logic        wr_stb;
    logic [15:0] wr_data;
    logic [15:0] rd_data;

    // Serial host engine
    vioc_serial u_serial (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .host_sclk  (host_sclk),
        .host_sdin  (host_sdin),
        .host_cs_n  (host_cs_n),
        .rd_data    (rd_data),
        .host_sdout (host_sdout),
        .addr       (addr),
        .wr_stb     (wr_stb),
        .wr_data    (wr_data)
    );

    // Address decode and read mux
    wire         ctrl_hit  = (addr == VIOC_CTRL_ADDR);
    wire         ctrl_wr   = wr_stb & ctrl_hit;
    assign rd_data   = ctrl_hit ? ctrl_reg : VIOC_READ_ZERO;
    assign ctrl_next = ctrl_wr ? (wr_data & VIOC_CTRL_WMASK) : ctrl_reg; // see R15

    // Timing format and H indication
    wire         fmt_cea   = ctrl_reg[VIOC_PIN_OVERRIDE_BIT] ? ctrl_reg[VIOC_FORMAT_SEL_BIT]
                                                             : timing_format_pin; // see R8 see R9
    wire         h_fvh     = ctrl_reg[VIOC_H_SELECT_BIT] ? trs_h_bit : line_blank; // see R4 see R5
    wire         h_next    = fmt_cea ? 1'b0 : h_fvh; // see R6

    // Datapath control outputs
    assign outs_next = {
        ctrl_reg[VIOC_SYNC_REMAP_BIT],      // see R1
        ctrl_reg[VIOC_FLAG_REFRESH_BIT],    // see R2
        ctrl_reg[VIOC_CHECK_INSERT_BIT],    // see R3
        ctrl_reg[VIOC_ANC_FIFO_BIT],        // see R7
        ctrl_reg[VIOC_BAD_WORD_BIT],        // see R10
        ctrl_reg[VIOC_ANC_CHECKSUM_BIT],    // see R11
        ctrl_reg[VIOC_LINE_CRC_BIT],        // see R12
        ctrl_reg[VIOC_LINE_NUMBER_BIT],     // see R13
        ctrl_reg[VIOC_SYNC_INSERT_BIT],     // see R14
        fmt_cea,
        h_next
    };

    // Control register and output flops
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= VIOC_CTRL_RESET;
            outs_reg <= 11'h000;
        end else begin
            ctrl_reg <= ctrl_next;
            outs_reg <= outs_next;
        end
    end

    assign sync_word_remap_off           = outs_reg[10];
    assign error_flag_refresh_off        = outs_reg[9];
    assign error_check_insert_off        = outs_reg[8];
    assign ancillary_capture_fifo_off    = outs_reg[7];
    assign bad_word_remap_off            = outs_reg[6];
    assign ancillary_checksum_insert_off = outs_reg[5];
    assign line_crc_insert_off           = outs_reg[4];
    assign line_number_insert_off        = outs_reg[3];
    assign sync_word_insert_off          = outs_reg[2];
    assign cea_timing_sel                = outs_reg[1];
    assign h_indication                  = outs_reg[0];

    // Checks
    sequence s_ctrl_write;
        wr_stb && ctrl_hit;
    endsequence

    property p_sync_remap;
        @(posedge sys_clk) disable iff (reset)
        s_ctrl_write |-> ##2 (sync_word_remap_off == $past(wr_data[VIOC_SYNC_REMAP_BIT], 2));
    endproperty
    a_sync_remap: assert property (p_sync_remap) else $error("remap off not from write"); // see R1

    property p_flag_refresh;
        @(posedge sys_clk) disable iff (reset)
        s_ctrl_write |-> ##2 (error_flag_refresh_off == $past(wr_data[VIOC_FLAG_REFRESH_BIT], 2));
    endproperty
    a_flag_refresh: assert property (p_flag_refresh) else $error("flag refresh off wrong"); // see R2

    property p_check_insert;
        @(posedge sys_clk) disable iff (reset)
        s_ctrl_write |-> ##2 (error_check_insert_off == $past(wr_data[VIOC_CHECK_INSERT_BIT], 2));
    endproperty
    a_check_insert: assert property (p_check_insert) else $error("check insert off wrong"); // see R3

    property p_h_line;
        @(posedge sys_clk) disable iff (reset)
        (!fmt_cea && !ctrl_reg[VIOC_H_SELECT_BIT]) |=> (h_indication == $past(line_blank));
    endproperty
    a_h_line: assert property (p_h_line) else $error("H not line blanking"); // see R4

    property p_h_trs;
        @(posedge sys_clk) disable iff (reset)
        (!fmt_cea && ctrl_reg[VIOC_H_SELECT_BIT]) |=> (h_indication == $past(trs_h_bit));
    endproperty
    a_h_trs: assert property (p_h_trs) else $error("H not from sync word H bit"); // see R5

    property p_h_cea;
        @(posedge sys_clk) disable iff (reset)
        cea_timing_sel |-> !h_indication;
    endproperty
    a_h_cea: assert property (p_h_cea) else $error("H active under CEA format"); // see R6

    property p_fifo_off;
        @(posedge sys_clk) disable iff (reset)
        s_ctrl_write |-> ##2 (ancillary_capture_fifo_off == $past(wr_data[VIOC_ANC_FIFO_BIT], 2));
    endproperty
    a_fifo_off: assert property (p_fifo_off) else $error("FIFO off wrong"); // see R7

    property p_pin_override;
        @(posedge sys_clk) disable iff (reset)
        ctrl_reg[VIOC_PIN_OVERRIDE_BIT] |=> (cea_timing_sel == $past(ctrl_reg[VIOC_FORMAT_SEL_BIT]));
    endproperty
    a_pin_override: assert property (p_pin_override) else $error("format not from register"); // see R8

    property p_pin_follow;
        @(posedge sys_clk) disable iff (reset)
        !ctrl_reg[VIOC_PIN_OVERRIDE_BIT] |=> (cea_timing_sel == $past(timing_format_pin));
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("format not from pin"); // see R9

    property p_bad_word;
        @(posedge sys_clk) disable iff (reset)
        s_ctrl_write |-> ##2 (bad_word_remap_off == $past(wr_data[VIOC_BAD_WORD_BIT], 2));
    endproperty
    a_bad_word: assert property (p_bad_word) else $error("bad word off wrong"); // see R10

    property p_inserts;
        @(posedge sys_clk) disable iff (reset)
        s_ctrl_write |-> ##2 ({ancillary_checksum_insert_off, line_crc_insert_off,
                               line_number_insert_off, sync_word_insert_off} == $past(wr_data[3:0], 2));
    endproperty
    a_inserts: assert property (p_inserts) else $error("insert off bits wrong"); // see R11 see R12 see R13 see R14

    property p_top_zero;
        @(posedge sys_clk) disable iff (reset)
        s_ctrl_write |=> (ctrl_reg[15] == 1'b0) && (ctrl_reg[14:0] == $past(wr_data[14:0]));
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("register write image wrong"); // see R15
endmodule // vioc_top
`default_nettype wire

// File: vioc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module vioc_host_model (
    input  wire logic        sys_clk,     // System clock
    input  wire logic        go,          // Start one access
    input  wire logic        go_rd,       // Read when high
    input  wire logic        go_ainc,     // Auto-increment, two data words
    input  wire logic [11:0] go_addr,     // Target address
    input  wire logic [15:0] go_data,     // Word to write
    input  wire logic        host_sdout,  // Serial data back
    output logic             host_sclk,   // Burst clock
    output logic             host_sdin,   // Serial data out
    output logic             host_cs_n,   // Select, low
    output logic             done,        // Access finished
    output logic [15:0]      rword        // Word read back
);
    logic [47:0] frame;
    logic        rd;
    int          nbits;

    // Command then one or two data words, MSB first, three cycles per clock phase
    initial begin
        host_sclk = 1'b0;
        host_sdin = 1'b0;
        host_cs_n = 1'b1;
        done      = 1'b0;
        rword     = 16'h0000;
        forever begin
            @(posedge sys_clk);
            done <= 1'b0;
            if (go !== 1'b1) begin
                host_sdin <= ~host_sdin;  // Idle line never holds a stale bit
            end else begin
                rd        = go_rd;
                frame     = {go_rd, 2'h0, go_ainc, go_addr, go_data, go_data};
                nbits     = go_ainc ? 48 : 32;
                host_cs_n <= 1'b0;
                for (int i = 0; i < nbits; i++) begin
                    host_sdin <= (rd && i > 15) ? ~host_sdin : frame[47-i];
                    repeat (3) @(posedge sys_clk);
                    if (rd && i > 15) rword <= {rword[14:0], host_sdout};
                    host_sclk <= 1'b1;
                    repeat (3) @(posedge sys_clk);
                    host_sclk <= 1'b0;
                end
                repeat (3) @(posedge sys_clk);
                host_cs_n <= 1'b1;
                done      <= 1'b1;
            end
        end
    end
endmodule // vioc_host_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import vioc_pkg::*;
    typedef struct { string what; logic [15:0] exp; } vioc_note_t;
    logic        sys_clk, reset, go, go_rd, go_ainc, snap, pin, lb, th;
    logic        sclk, sdin, cs_n, sdout, done;
    logic [11:0] go_addr;
    logic [15:0] go_data, rword, ctrl, obs, seen;
    logic        o14, o12, o11, o9, o4, o3, o2, o1, o0, cea, hind;
    vioc_note_t  notes[$];
    vioc_note_t  nt;
    int          miscompares = 0;
    int          num_checks  = 0;
    int          cycles      = 0;
    int          ctl_bits[9] = '{14, 12, 11, 9, 4, 3, 2, 1, 0};

    vioc_top DUT (.sys_clk(sys_clk), .reset(reset), .host_sclk(sclk), .host_sdin(sdin),
        .host_cs_n(cs_n), .host_sdout(sdout), .timing_format_pin(pin), .line_blank(lb),
        .trs_h_bit(th), .sync_word_remap_off(o14), .error_flag_refresh_off(o12),
        .error_check_insert_off(o11), .ancillary_capture_fifo_off(o9), .bad_word_remap_off(o4),
        .ancillary_checksum_insert_off(o3), .line_crc_insert_off(o2), .line_number_insert_off(o1),
        .sync_word_insert_off(o0), .cea_timing_sel(cea), .h_indication(hind));

    vioc_host_model host (.sys_clk(sys_clk), .go(go), .go_rd(go_rd), .go_ainc(go_ainc), .go_addr(go_addr),
        .go_data(go_data), .host_sdout(sdout), .host_sclk(sclk), .host_sdin(sdin),
        .host_cs_n(cs_n), .done(done), .rword(rword));

    // Outputs packed at their control bit positions
    assign obs = {1'b0, o14, 1'b0, o12, o11, hind, o9, 1'b0, 1'b0, cea, 1'b0, o4, o3, o2, o1, o0};

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Expected output vector from the register image and pins
    function automatic logic [15:0] exp_outs();
        logic [15:0] o;
        logic        c;
        c     = ctrl[7] ? ctrl[6] : pin;
        o     = ctrl & 16'h5A1F;
        o[6]  = c;
        o[10] = c ? 1'b0 : (ctrl[10] ? th : lb);
        return o;
    endfunction

    task automatic final_report();
        if (notes.size() != 0) miscompares++;
        if (miscompares == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic host_access(input logic rd, input logic [11:0] a, input logic [15:0] d);
        int n;
        go_rd   <= rd;
        go_addr <= a;
        go_data <= d;
        go      <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 400) miscompares++;
        @(posedge sys_clk);
    endtask

    task automatic write_word(input logic [11:0] a, input logic [15:0] d);
        host_access(1'b0, a, d);
        if (a == 12'h000) ctrl = d & 16'h7FFF;
    endtask

    task automatic read_word(input logic [11:0] a, input logic [15:0] e, input string what);
        notes.push_back('{what, e});
        host_access(1'b1, a, 16'h0000);
    endtask

    task automatic expect_outs();
        notes.push_back('{"outputs", exp_outs()});
        snap <= 1'b1;
        @(posedge sys_clk);
        snap <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Monitor: oldest note against each read word or output snapshot
    always @(posedge sys_clk) begin
        if ((done === 1'b1 && go_rd === 1'b1) || snap === 1'b1) begin
            seen = (snap === 1'b1) ? obs : rword;
            num_checks++;
            if (notes.size() == 0) begin
                $display("Error unexpected result seen %h", seen);
                miscompares++;
            end else begin
                nt = notes.pop_front();
                if (seen !== nt.exp) begin
                    $display("Error %s expected %h seen %h", nt.what, nt.exp, seen);
                    miscompares++;
                end
            end
        end
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        reset   = 1'b1;
        go      = 1'b0;
        go_rd   = 1'b0;
        go_ainc = 1'b0;
        go_addr = 12'h000;
        go_data = 16'h0000;
        snap    = 1'b0;
        pin     = 1'b0;
        lb      = 1'b0;
        th      = 1'b0;
        ctrl    = 16'h0000;
        void'($urandom(32'h8D64));
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        expect_outs();
        read_word(12'h000, 16'h0000, "reset value");
        foreach (ctl_bits[k]) begin
            write_word(12'h000, 16'h0001 << ctl_bits[k]);
            expect_outs();
        end
        repeat (4) begin
            write_word(12'h000, 16'($urandom));
            read_word(12'h000, ctrl, "readback");
            expect_outs();
        end
        write_word(12'h000, 16'hFFFF);
        read_word(12'h000, 16'h7FFF, "top bit");
        write_word(12'h001, 16'h0F0F);
        read_word(12'h001, 16'h0000, "unmapped");
        read_word(12'h000, 16'h7FFF, "kept after unmapped");
        // Auto-increment from FFFh wraps, second word lands in the register
        go_ainc <= 1'b1;
        write_word(12'hFFF, 16'h2A55);
        go_ainc <= 1'b0;
        ctrl = 16'h2A55;
        read_word(12'h000, 16'h2A55, "auto increment");
        expect_outs();
        for (int m = 0; m < 8; m++) begin
            write_word(12'h000, {5'h00, m[2], 2'h0, m[1], m[0], 6'h00});
            for (int j = 0; j < 8; j++) begin
                pin <= j[2];
                lb  <= j[1];
                th  <= j[0];
                repeat (3) @(posedge sys_clk);
                expect_outs();
            end
        end
        final_report();
    end
endmodule // tb
`default_nettype wire
